// ### hw/adcsp_pkg.sv
// ==========================================================================
// Types shared by the sample clock and packing block
package adcsp_pkg;

  // Requested sample rate band.
  typedef enum logic [1:0] {
    ADCSP_RANGE_LOW,
    ADCSP_RANGE_MID,
    ADCSP_RANGE_HIGH
  } adcsp_range_type;

  // Word emission sequencer.
  typedef enum logic {
    ADCSP_ST_IDLE,
    ADCSP_ST_SEND
  } adcsp_state_type;

  // Achieved rate divider.
  typedef enum logic {
    ADCSP_DIV_IDLE,
    ADCSP_DIV_RUN
  } adcsp_div_type;

endpackage

// ### hw/adcsp_regs.svh
`ifndef ADCSP_REGS_SVH
`define ADCSP_REGS_SVH

// ==========================================================================
// Channel and word geometry
`define ADCSP_NUM_CH 8
`define ADCSP_WORD_W 32
`define ADCSP_SAMPLE_W 24
`define ADCSP_SLICE_W 16
`define ADCSP_SLICE_MAX 4'h8

// ==========================================================================
// Reference clock and PLL factor limits
`define ADCSP_REF_HZ 24'hC3_5000
`define ADCSP_REF_DIV_MIN 11'h002
`define ADCSP_REF_DIV_MAX 11'h033
`define ADCSP_FB_MIN 11'h008
`define ADCSP_FB_MAX 11'h640
`define ADCSP_POST_MIN 11'h001
`define ADCSP_POST_MAX 11'h07F

// ==========================================================================
// Oversampling ratios, ratio divider values and result scaling shifts
`define ADCSP_OSR_LOW 9'h100
`define ADCSP_OSR_MID 9'h080
`define ADCSP_OSR_HIGH 9'h040
`define ADCSP_RATIO_LOW 11'h400
`define ADCSP_RATIO_HIGH 11'h100
`define ADCSP_SHIFT_LOW 5'h0F
`define ADCSP_SHIFT_MID 5'h10
`define ADCSP_SHIFT_HIGH 5'h11
`define ADCSP_SAT_POS 26'h0_7F_FFFF
`define ADCSP_SAT_NEG 26'h3_80_0000

// ==========================================================================
// Rate divider timing: one quotient bit per clock
`define ADCSP_DIV_STEPS 6'h23

`endif

// ### hw/adcsp_skid.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Two-entry skid buffer; every output is a flip-flop
module adcsp_skid #(
  parameter int W = 32
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Filling side.
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side.
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [W-1:0] main_data_reg, main_data_next, skid_data_reg, skid_data_next;
  logic main_valid_reg, main_valid_next, skid_valid_reg, skid_valid_next;
  logic accept;

  // Ready drops only when the spare entry is full, so a stall costs no word.
  always_comb begin
    accept = in_valid & ~skid_valid_reg;
    main_data_next = main_data_reg;
    main_valid_next = main_valid_reg;
    skid_data_next = skid_data_reg;
    skid_valid_next = skid_valid_reg;
    if (!main_valid_reg || out_ready) begin
      if (skid_valid_reg) begin
        main_data_next = skid_data_reg;
        main_valid_next = 1'b1;
        skid_valid_next = accept;
        skid_data_next = in_data;
      end else begin
        main_data_next = in_data;
        main_valid_next = accept;
      end
    end else if (accept) begin
      skid_data_next = in_data;
      skid_valid_next = 1'b1;
    end
  end

  // State registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      main_data_reg <= '0;
      main_valid_reg <= 1'b0;
      skid_data_reg <= '0;
      skid_valid_reg <= 1'b0;
    end else begin
      main_data_reg <= main_data_next;
      main_valid_reg <= main_valid_next;
      skid_data_reg <= skid_data_next;
      skid_valid_reg <= skid_valid_next;
    end
  end

  assign out_data = main_data_reg;
  assign out_valid = main_valid_reg;
  assign in_ready = ~skid_valid_reg;
endmodule // adcsp_skid

`default_nettype wire

// ### hw/adcsp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcsp_regs.svh"

// ==========================================================================
// What this block does
// - Eight independent channels, each decimating its own modulator bit stream.
// - Rates up to 204.8 kS/s, 24-bit result per channel.
// - Below 51.2 kS/s the modulator runs at 256 times the rate.
// - From 51.2 to 102.4 kS/s the modulator runs at 128 times.
// - Above 102.4 kS/s the oversampling ratio is 64.
// - Decimator turns the 1-bit stream into 24-bit words at output rate.
// - Decimator is a linear phase box sum with only modest rejection above 0.5465 fs.
// - Rate is reference over ref divider, times feedback, over post and ratio.
// - PLL factors are integers held to 2..51, 8..1600 and 1..127.
// - Ratio divider is 1024 up to 51.2 kS/s, otherwise 256.
// - The exact achieved sample rate is readable.
// - One common sample rate for all channels.
// - Default format puts each sample in its own 32-bit word.
// - Packed mode puts two 16-bit slices per word, lower channel high.
// - The packed 16-bit slice window is selectable.
// - Out-of-range results saturate instead of wrapping; a packed slice with a nonzero shift drops the top bits and wraps.
module adcsp_top #(
  parameter int NUM_CH = `ADCSP_NUM_CH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Modulator bit streams, one bit per channel per valid pulse.
  input wire logic [NUM_CH-1:0] mod_bit,
  input wire logic mod_bit_valid,
  // Rate band and PLL factor requests.
  input wire adcsp_pkg::adcsp_range_type rate_range,
  input wire logic [5:0] ref_divider,
  input wire logic [10:0] feedback_factor,
  input wire logic [6:0] post_divider,
  // Output format.
  input wire logic packed_en,
  input wire logic [3:0] slice_shift,
  input wire logic [3:0] active_channels,
  // PLL settings actually applied and the rate they give.
  output logic [5:0] pll_ref_divider,
  output logic [10:0] pll_feedback_factor,
  output logic [6:0] pll_post_divider,
  output logic [8:0] osr,
  output logic [10:0] ratio_divider,
  output logic [31:0] achieved_rate_hz,
  output logic achieved_rate_valid,
  // Sample word stream toward the host.
  output logic [`ADCSP_WORD_W-1:0] word_data,
  output logic word_valid,
  input wire logic word_ready,
  output logic frame_overrun
);
  import adcsp_pkg::*;

  // ========================================================================
  // Helper functions
  function automatic logic [10:0] clamp11(logic [10:0] v, logic [10:0] lo,
                                          logic [10:0] hi);
    clamp11 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [8:0] osr_of(adcsp_range_type r);
    case (r)
      ADCSP_RANGE_LOW: osr_of = `ADCSP_OSR_LOW;
      ADCSP_RANGE_MID: osr_of = `ADCSP_OSR_MID;
      default: osr_of = `ADCSP_OSR_HIGH;
    endcase
  endfunction

  // Box sum of +-1 bits scaled to full 24-bit range, clipped at both ends.
  function automatic logic [23:0] scale_sat(logic signed [9:0] s, adcsp_range_type r);
    logic signed [25:0] w;
    logic [4:0] sh;
    case (r)
      ADCSP_RANGE_LOW: sh = `ADCSP_SHIFT_LOW;
      ADCSP_RANGE_MID: sh = `ADCSP_SHIFT_MID;
      default: sh = `ADCSP_SHIFT_HIGH;
    endcase
    w = 26'(s) <<< sh;
    if (w > $signed(`ADCSP_SAT_POS)) scale_sat = 24'h7F_FFFF;
    else if (w < $signed(`ADCSP_SAT_NEG)) scale_sat = 24'h80_0000;
    else scale_sat = w[23:0];
  endfunction

  function automatic logic [15:0] slice_of(logic [23:0] s, logic [3:0] sh);
    slice_of = 16'(s >> (4'h8 - sh));
  endfunction

  // ========================================================================
  // PLL factors, oversampling band and ratio divider
  logic [5:0] ref_div_reg, ref_div_next;
  logic [10:0] fb_reg, fb_next;
  logic [6:0] post_reg, post_next;
  adcsp_range_type range_reg, range_next;
  logic [8:0] osr_reg, osr_next;
  logic [10:0] ratio_reg, ratio_next;
  logic [8:0] bit_cnt_reg, bit_cnt_next;

  // Band changes only take effect between samples so no result mixes two ratios.
  always_comb begin
    ref_div_next = 6'(clamp11({5'h00, ref_divider}, `ADCSP_REF_DIV_MIN, `ADCSP_REF_DIV_MAX));
    fb_next = clamp11(feedback_factor, `ADCSP_FB_MIN, `ADCSP_FB_MAX);
    post_next = 7'(clamp11({4'h0, post_divider}, `ADCSP_POST_MIN, `ADCSP_POST_MAX));
    range_next = (bit_cnt_reg == 9'h000) ? rate_range : range_reg;
    osr_next = osr_of(range_next);
    ratio_next = (range_next == ADCSP_RANGE_LOW) ? `ADCSP_RATIO_LOW : `ADCSP_RATIO_HIGH;
  end

  // Configuration registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      ref_div_reg <= 6'h02;
      fb_reg <= 11'h008;
      post_reg <= 7'h01;
      range_reg <= ADCSP_RANGE_LOW;
      osr_reg <= 9'h100;
      ratio_reg <= 11'h400;
    end else begin
      ref_div_reg <= ref_div_next;
      fb_reg <= fb_next;
      post_reg <= post_next;
      range_reg <= range_next;
      osr_reg <= osr_next;
      ratio_reg <= ratio_next;
    end
  end

  // ========================================================================
  // Achieved rate: reference times feedback over the three dividers
  adcsp_div_type div_reg, div_next;
  logic [34:0] num_reg, num_next;
  logic [23:0] rem_reg, rem_next, rem_sh;
  logic [22:0] den_reg, den_next;
  logic [5:0] step_reg, step_next;
  logic [30:0] snap_reg, snap_next, cfg_now;
  logic [31:0] rate_reg, rate_next;
  logic rate_valid_reg, rate_valid_next;
  logic div_start;

  // Restoring division, one bit per clock; a change mid-run restarts after it.
  always_comb begin
    cfg_now = {ref_div_reg, fb_reg, post_reg, range_reg, 5'h00};
    div_start = (div_reg == ADCSP_DIV_IDLE) && (cfg_now != snap_reg);
    div_next = div_reg;
    num_next = num_reg;
    rem_next = rem_reg;
    den_next = den_reg;
    step_next = step_reg;
    snap_next = snap_reg;
    rate_next = rate_reg;
    rate_valid_next = rate_valid_reg;
    rem_sh = {rem_reg[22:0], num_reg[34]};
    case (div_reg)
      ADCSP_DIV_IDLE: begin
        if (div_start) begin
          num_next = 35'(`ADCSP_REF_HZ) * 35'(fb_reg);
          den_next = 23'(ref_div_reg) * 23'(post_reg) * 23'(ratio_reg);
          rem_next = 24'h00_0000;
          step_next = `ADCSP_DIV_STEPS;
          snap_next = cfg_now;
          rate_valid_next = 1'b0;
          div_next = ADCSP_DIV_RUN;
        end
      end
      ADCSP_DIV_RUN: begin
        if (rem_sh >= {1'b0, den_reg}) begin
          rem_next = rem_sh - {1'b0, den_reg};
          num_next = {num_reg[33:0], 1'b1};
        end else begin
          rem_next = rem_sh;
          num_next = {num_reg[33:0], 1'b0};
        end
        step_next = step_reg - 6'h01;
        if (step_reg == 6'h01) begin
          rate_next = num_next[31:0];
          rate_valid_next = 1'b1;
          div_next = ADCSP_DIV_IDLE;
        end
      end
      default: div_next = ADCSP_DIV_IDLE;
    endcase
  end

  // Divider registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      div_reg <= ADCSP_DIV_IDLE;
      num_reg <= '0;
      rem_reg <= '0;
      den_reg <= '0;
      step_reg <= '0;
      snap_reg <= '0;
      rate_reg <= '0;
      rate_valid_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      num_reg <= num_next;
      rem_reg <= rem_next;
      den_reg <= den_next;
      step_reg <= step_next;
      snap_reg <= snap_next;
      rate_reg <= rate_next;
      rate_valid_reg <= rate_valid_next;
    end
  end

  // ========================================================================
  // Decimation: one box sum per channel over one oversampling period
  logic signed [9:0] acc_reg [NUM_CH];
  logic signed [9:0] acc_next [NUM_CH];
  logic signed [9:0] acc_final [NUM_CH];
  logic [23:0] sample_reg [NUM_CH];
  logic [23:0] sample_next [NUM_CH];
  logic strobe, start_frame;

  // A box sum is symmetric, hence linear phase; its stop band is modest.
  always_comb begin
    strobe = mod_bit_valid && (bit_cnt_reg == osr_reg - 9'h001);
    bit_cnt_next = bit_cnt_reg;
    if (mod_bit_valid) bit_cnt_next = strobe ? 9'h000 : bit_cnt_reg + 9'h001;
    for (int c = 0; c < NUM_CH; c++) begin
      acc_final[c] = ((bit_cnt_reg == 9'h000) ? 10'sh000 : acc_reg[c]) +
                     (mod_bit[c] ? 10'sh001 : 10'sh3FF);
      acc_next[c] = mod_bit_valid ? acc_final[c] : acc_reg[c];
      sample_next[c] = (strobe && start_frame) ? scale_sat(acc_final[c], range_reg)
                                               : sample_reg[c];
    end
  end

  // Decimator registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      bit_cnt_reg <= 9'h000;
      for (int c = 0; c < NUM_CH; c++) begin
        acc_reg[c] <= 10'sh000;
        sample_reg[c] <= 24'h00_0000;
      end
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      for (int c = 0; c < NUM_CH; c++) begin
        acc_reg[c] <= acc_next[c];
        sample_reg[c] <= sample_next[c];
      end
    end
  end

  // ========================================================================
  // Word emission into the skid buffer
  adcsp_state_type state_reg, state_next;
  logic [3:0] word_idx_reg, word_idx_next, last_reg, last_next;
  logic [3:0] nch_reg, nch_next, shift_reg, shift_next, nch_req;
  logic packed_reg, packed_next, overrun_reg, overrun_next;
  logic push_ready, done_now;
  logic [`ADCSP_WORD_W-1:0] push_data;
  logic [3:0] ch_a, ch_b;

  // Format is frozen per frame so a mid-frame change cannot tear a word.
  always_comb begin
    nch_req = 4'(clamp11({7'h00, active_channels}, 11'h001, 11'(NUM_CH)));
    done_now = (state_reg == ADCSP_ST_SEND) && push_ready && (word_idx_reg == last_reg);
    start_frame = (state_reg == ADCSP_ST_IDLE) || done_now;
    state_next = state_reg;
    word_idx_next = word_idx_reg;
    last_next = last_reg;
    nch_next = nch_reg;
    shift_next = shift_reg;
    packed_next = packed_reg;
    overrun_next = 1'b0;
    if (strobe && start_frame) begin
      state_next = ADCSP_ST_SEND;
      word_idx_next = 4'h0;
      nch_next = nch_req;
      packed_next = packed_en;
      shift_next = (slice_shift > `ADCSP_SLICE_MAX) ? `ADCSP_SLICE_MAX : slice_shift;
      last_next = packed_en ? ((nch_req + 4'h1) >> 1) - 4'h1 : nch_req - 4'h1;
    end else begin
      // A late strobe is flagged, but the word in flight must still advance.
      overrun_next = strobe;
      if (done_now) begin
        state_next = ADCSP_ST_IDLE;
      end else if ((state_reg == ADCSP_ST_SEND) && push_ready) begin
        word_idx_next = word_idx_reg + 4'h1;
      end
    end
    // Word contents for the current index.
    ch_a = packed_reg ? {word_idx_reg[2:0], 1'b0} : word_idx_reg;
    ch_b = ch_a + 4'h1;
    if (packed_reg) begin
      push_data[31:16] = slice_of(sample_reg[ch_a[2:0]], shift_reg);
      push_data[15:0] = (ch_b < nch_reg) ? slice_of(sample_reg[ch_b[2:0]], shift_reg)
                                         : 16'h0000;
    end else begin
      push_data = {{8{sample_reg[ch_a[2:0]][23]}}, sample_reg[ch_a[2:0]]};
    end
  end

  // Sequencer registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ADCSP_ST_IDLE;
      word_idx_reg <= 4'h0;
      last_reg <= 4'h0;
      nch_reg <= 4'h1;
      shift_reg <= 4'h0;
      packed_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      word_idx_reg <= word_idx_next;
      last_reg <= last_next;
      nch_reg <= nch_next;
      shift_reg <= shift_next;
      packed_reg <= packed_next;
      overrun_reg <= overrun_next;
    end
  end

  // The buffer's ready holds the sequencer, so host stalls lose no word.
  adcsp_skid #(.W(`ADCSP_WORD_W)) adcsp_skid_inst (
    .clk(clk),
    .reset(reset),
    .in_data(push_data),
    .in_valid(state_reg == ADCSP_ST_SEND),
    .in_ready(push_ready),
    .out_data(word_data),
    .out_valid(word_valid),
    .out_ready(word_ready)
  );

  // Register-driven outputs.
  assign pll_ref_divider = ref_div_reg;
  assign pll_feedback_factor = fb_reg;
  assign pll_post_divider = post_reg;
  assign osr = osr_reg;
  assign ratio_divider = ratio_reg;
  assign achieved_rate_hz = rate_reg;
  assign achieved_rate_valid = rate_valid_reg;
  assign frame_overrun = overrun_reg;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_osr_low;
    (bit_cnt_reg == 9'h000 && rate_range == ADCSP_RANGE_LOW) |=> osr == 9'h100;
  endproperty
  a_osr_low: assert property (p_osr_low) else $error("low band ratio not 256");
  property p_osr_mid;
    (bit_cnt_reg == 9'h000 && rate_range == ADCSP_RANGE_MID) |=> osr == 9'h080;
  endproperty
  a_osr_mid: assert property (p_osr_mid) else $error("mid band ratio not 128");
  property p_osr_high;
    (bit_cnt_reg == 9'h000 && rate_range == ADCSP_RANGE_HIGH) |=> osr == 9'h040;
  endproperty
  a_osr_high: assert property (p_osr_high) else $error("high band ratio not 64");
  property p_ratio;
    (bit_cnt_reg == 9'h000) |=>
      ratio_divider == (($past(rate_range) == ADCSP_RANGE_LOW) ? 11'h400 : 11'h100);
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio divider wrong");
  property p_limits;
    ((ref_divider < 6'h02) |=> pll_ref_divider == 6'h02) and
      ((feedback_factor > 11'h640) |=> pll_feedback_factor == 11'h640);
  endproperty
  a_limits: assert property (p_limits) else $error("factor not clamped");
  property p_rate;
    div_start |=> !achieved_rate_valid ##35 achieved_rate_valid;
  endproperty
  a_rate: assert property (p_rate) else $error("rate not ready in 36 cycles");
  property p_latch;
    (strobe && state_reg == ADCSP_ST_IDLE) |=>
      state_reg == ADCSP_ST_SEND && word_idx_reg == 4'h0 && sample_reg[0] == $past(sample_next[0]);
  endproperty
  a_latch: assert property (p_latch) else $error("frame not started on strobe");
  property p_sat;
    (strobe && start_frame && acc_final[0] == $signed({1'b0, osr_reg})) |=>
      sample_reg[0] == 24'h7F_FFFF;
  endproperty
  a_sat: assert property (p_sat) else $error("full scale did not saturate");
  property p_sign;
    (state_reg == ADCSP_ST_SEND && !packed_reg) |-> push_data[31:24] == {8{push_data[23]}};
  endproperty
  a_sign: assert property (p_sign) else $error("top byte not sign");
  property p_zero_tail;
    (state_reg == ADCSP_ST_SEND && packed_reg && word_idx_reg == last_reg && nch_reg[0])
      |-> push_data[15:0] == 16'h0000;
  endproperty
  a_zero_tail: assert property (p_zero_tail) else $error("odd tail not zero");

  c_packed: cover property (done_now && packed_reg);
  c_overrun: cover property (frame_overrun);
  c_stall: cover property (word_valid && !word_ready ##1 !push_ready);
endmodule // adcsp_top

`default_nettype wire

// ### tb/adcsp_far_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Far side: eight modulators and a host draining the word stream
module adcsp_far_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Bench controls.
  input wire logic [7:0] pattern,
  input wire logic slow,
  input wire logic hold,
  // Modulator streams.
  output logic [7:0] mod_bit,
  output logic mod_bit_valid,
  // Host side of the stream.
  input wire logic [31:0] word_data,
  input wire logic word_valid,
  output logic word_ready
);
  logic phase_reg;
  logic [31:0] rx_q[$];

  // Quiet outputs before the first edge.
  initial begin
    mod_bit = 8'h00;
    mod_bit_valid = 1'b0;
    word_ready = 1'b0;
    phase_reg = 1'b0;
  end

  // Takes a word on each accepted handshake, then moves just after the edge.
  // one common valid
  always @(posedge clk) begin
    if (word_valid === 1'b1 && word_ready === 1'b1) begin
      rx_q.push_back(word_data);
    end
    #1;
    phase_reg = ~phase_reg;
    mod_bit_valid = ~reset;
    mod_bit = pattern;
    // A slow host only accepts every other cycle, so the buffer must absorb the stall.
    word_ready = ~hold & (~slow | phase_reg);
  end
endmodule // adcsp_far_model

`default_nettype wire

// ### tb/adcsp_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Bench for the sample clock and packing block
module adcsp_top_bench;
  import adcsp_pkg::*;
  typedef struct {
    logic [1:0] band;
    logic pk;
    logic [3:0] sh;
    logic [3:0] n;
    logic [7:0] pat;
    logic slow;
    logic [8:0] osr;
    logic [10:0] ratio;
    int nw;
  } adcsp_row_type;
  logic clk, reset, packed_en, slow, hold, mod_bit_valid, achieved_rate_valid;
  logic word_valid, word_ready, frame_overrun;
  adcsp_range_type rate_range;
  logic [5:0] ref_divider, pll_ref_divider;
  logic [10:0] feedback_factor, pll_feedback_factor, ratio_divider;
  logic [6:0] post_divider, pll_post_divider;
  logic [3:0] slice_shift, active_channels;
  logic [7:0] pattern, mod_bit;
  logic [8:0] osr;
  logic [31:0] achieved_rate_hz, word_data;
  int bad_count, num_checks;
  adcsp_row_type rows[8];

  adcsp_top adcsp_top_inst (.clk(clk), .reset(reset), .mod_bit(mod_bit),
    .mod_bit_valid(mod_bit_valid), .rate_range(rate_range), .ref_divider(ref_divider),
    .feedback_factor(feedback_factor), .post_divider(post_divider), .packed_en(packed_en),
    .slice_shift(slice_shift), .active_channels(active_channels),
    .pll_ref_divider(pll_ref_divider), .pll_feedback_factor(pll_feedback_factor),
    .pll_post_divider(pll_post_divider), .osr(osr), .ratio_divider(ratio_divider),
    .achieved_rate_hz(achieved_rate_hz), .achieved_rate_valid(achieved_rate_valid),
    .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready),
    .frame_overrun(frame_overrun));

  adcsp_far_model adcsp_far_model_inst (.clk(clk), .reset(reset), .pattern(pattern),
    .slow(slow), .hold(hold), .mod_bit(mod_bit), .mod_bit_valid(mod_bit_valid),
    .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready));

  // ==========================================================================
  // Helpers
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Bounded wait: 0/1 word_valid level, 2 overrun pulse, 3 rate valid.
  task automatic wait_until(input int what);
    int i;
    for (i = 0; i < 600; i++) begin
      if ((what == 0 && word_valid === 1'b0) || (what == 1 && word_valid === 1'b1) ||
          (what == 2 && frame_overrun === 1'b1) || (what == 3 && achieved_rate_valid === 1'b1))
        return;
      tick();
    end
    bad_count++;
    final_report();
  endtask

  // A constant bit stream drives the decimator to either full-scale end.
  function automatic logic [23:0] sat(input logic b);
    return b ? 24'h7F_FFFF : 24'h80_0000;
  endfunction

  function automatic logic [31:0] exp_word(input adcsp_row_type r, input int k);
    int n;
    int s;
    logic [23:0] hi;
    logic [23:0] lo;
    n = (r.n == 0) ? 1 : ((r.n > 8) ? 8 : int'(r.n));
    s = (r.sh > 8) ? 8 : int'(r.sh);
    if (!r.pk) begin
      hi = sat(r.pat[k]);
      return {{8{hi[23]}}, hi};
    end
    hi = sat(r.pat[2*k]) >> (8 - s);
    lo = (2*k+1 < n) ? (sat(r.pat[2*k+1]) >> (8 - s)) : 24'h00_0000;
    return {hi[15:0], lo[15:0]};
  endfunction

  // Two frame gaps are skipped so no frame straddles the settings change.
  task automatic run_row(input adcsp_row_type r);
    int i;
    rate_range = adcsp_range_type'(r.band);
    packed_en = r.pk;
    slice_shift = r.sh;
    active_channels = r.n;
    pattern = r.pat;
    slow = r.slow;
    repeat (2) begin
      wait_until(1);
      wait_until(0);
    end
    adcsp_far_model_inst.rx_q.delete();
    for (i = 0; i < 600 && adcsp_far_model_inst.rx_q.size() < r.nw; i++) tick();
    if (adcsp_far_model_inst.rx_q.size() < r.nw) begin
      bad_count++;
      final_report();
    end
    chk(32'(osr), 32'(r.osr));
    chk(32'(ratio_divider), 32'(r.ratio));
    for (i = 0; i < r.nw; i++)
      chk(adcsp_far_model_inst.rx_q[i], exp_word(r, i));
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    bad_count = 0;
    num_checks = 0;
    rows = '{'{2'h2, 1'b0, 4'h0, 4'h8, 8'hA5, 1'b0, 9'h040, 11'h100, 8},
             '{2'h2, 1'b1, 4'h0, 4'h8, 8'hA5, 1'b0, 9'h040, 11'h100, 4},
             '{2'h2, 1'b1, 4'h2, 4'h8, 8'h3C, 1'b1, 9'h040, 11'h100, 4},
             '{2'h3, 1'b1, 4'hC, 4'h3, 8'hA5, 1'b0, 9'h040, 11'h100, 2},
             '{2'h2, 1'b0, 4'h0, 4'h0, 8'h5A, 1'b0, 9'h040, 11'h100, 1},
             '{2'h2, 1'b0, 4'h0, 4'hF, 8'h0F, 1'b1, 9'h040, 11'h100, 8},
             '{2'h0, 1'b0, 4'h0, 4'h2, 8'h01, 1'b0, 9'h100, 11'h400, 2},
             '{2'h1, 1'b1, 4'h8, 4'h7, 8'hC3, 1'b0, 9'h080, 11'h100, 4}};
    reset = 1'b1;
    rate_range = ADCSP_RANGE_LOW;
    {ref_divider, feedback_factor, post_divider} = {6'h02, 11'h020, 7'h04};
    {packed_en, slice_shift, active_channels, pattern, slow, hold} = 19'h0_0000;
    repeat (3) @(posedge clk);
    #1;
    chk({pll_ref_divider, pll_feedback_factor, pll_post_divider}, {8'h00, 6'h02, 11'h008, 7'h01});
    chk({osr, ratio_divider, achieved_rate_valid, word_valid}, {9'h100, 11'h400, 2'h0});
    reset = 1'b0;
    foreach (rows[i]) run_row(rows[i]);
    // Out-of-range factors come back clamped one cycle later.
    {ref_divider, feedback_factor, post_divider} = {6'h01, 11'h000, 7'h00};
    tick();
    chk({pll_ref_divider, pll_feedback_factor, pll_post_divider}, {8'h00, 6'h02, 11'h008, 7'h01});
    {ref_divider, feedback_factor, post_divider} = {6'h3F, 11'h7FF, 7'h7F};
    tick();
    chk({pll_ref_divider, pll_feedback_factor, pll_post_divider}, {8'h00, 6'h33, 11'h640, 7'h7F});
    // Factors kept inside the stable range: 204.8 MHz, then 200000 and 160000 S/s.
    {ref_divider, feedback_factor, post_divider} = {6'h02, 11'h020, 7'h04};
    wait_until(3);
    tick();
    wait_until(3);
    chk(achieved_rate_hz, 32'h0003_0D40);
    post_divider = 7'h05;
    repeat (2) tick();
    chk(32'(achieved_rate_valid), 32'h0000_0000);
    wait_until(3);
    chk(achieved_rate_hz, 32'h0002_7100);
    // A host stall longer than a frame drops the next frame but keeps the buffered words.
    hold = 1'b1;
    wait_until(2);
    chk(32'(word_valid), 32'h0000_0001);
    tick();
    chk(32'(frame_overrun), 32'h0000_0000);
    hold = 1'b0;
    run_row(rows[0]);
    final_report();
  end
endmodule // adcsp_top_bench

`default_nettype wire
